// *** booth_mult_33x17.sv ***
// Radix-4 Booth-recoded multiplier, 33-bit by 17-bit, both signed.
// Assumes the caller extends unsigned operands with a zero sign bit.
module booth_mult_33x17 (
    input  wire logic [32:0] multiplicand,
    input  wire logic [16:0] multiplier,
    output logic      [49:0] product
);

    // Multiplier with an extra sign bit on top and the implicit zero below.
    logic [18:0] recode_bits;
    // Multiplicand sign-extended to product width, once and twice.
    logic [49:0] mcand_x1;
    logic [49:0] mcand_x2;
    // Running sum of partial products.
    logic [49:0] running [10];

    assign recode_bits = {multiplier[16], multiplier, 1'b0};
    assign mcand_x1    = {{17{multiplicand[32]}}, multiplicand};
    assign mcand_x2    = {mcand_x1[48:0], 1'b0};
    assign running[0]  = '0;

    // Each Booth digit selects 0, +-1 or +-2 times the multiplicand.
    for (genvar g = 0; g < 9; g++) begin : g_digit
        logic [49:0] pp;
        always_comb begin
            unique case (recode_bits[2*g+2 -: 3])
                3'h0, 3'h7: pp = '0;
                3'h1, 3'h2: pp = mcand_x1;
                3'h3:       pp = mcand_x2;
                3'h4:       pp = -mcand_x2;
                3'h5, 3'h6: pp = -mcand_x1;
            endcase
        end
        assign running[g+1] = running[g] + (pp << (2 * g));
    end

    assign product = running[9];

endmodule // booth_mult_33x17

// *** issue_pipe.sv ***
// Model of the integer pipe that offers operations to the unit.
// Assumes the bench calls offer and rest from its main sequence.
module issue_pipe
    import pq_types_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        issue_stall,
    output logic             issue_valid,
    output op_t              issue_op,
    output logic             issue_signed,
    output logic      [31:0] operand_a,
    output logic      [31:0] operand_b,
    output logic             timed_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle at time zero with no request offered.
    initial begin
        issue_valid = 1'b0;
        issue_op = product_to_accumulator;
        issue_signed = 1'b0;
        operand_a = 32'h0;
        operand_b = 32'h0;
        timed_out = 1'b0;
    end
    // Offers one operation and returns just after the edge that takes it.
    task automatic offer(input op_t op, input logic sg,
                         input logic [31:0] a, input logic [31:0] b);
        int n;
        @(negedge core_clk);
        issue_valid = 1'b1;
        issue_op = op;
        issue_signed = sg;
        operand_a = a;
        operand_b = b;
        n = 0;
        // The request stands unchanged while the unit stalls.
        while (issue_stall !== 1'b0 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 40) begin
            timed_out = 1'b1;
        end
        @(posedge core_clk);
    endtask
    // Releases the request; stale operands are inverted, not kept.
    task automatic rest();
        @(negedge core_clk);
        issue_valid = 1'b0;
        operand_a = ~operand_a;
        operand_b = ~operand_b;
    endtask
endmodule // issue_pipe

// *** pq_types_pkg.sv ***
// Types shared by the product and quotient unit, its checker, the pipe model and the bench.
// Assumes nothing of its surroundings.
package pq_types_pkg;

    // Operation issued by the integer pipe.
    typedef enum logic [2:0] {
        product_to_accumulator = 3'h0,
        product_accumulate_add = 3'h1,
        product_accumulate_sub = 3'h2,
        product_to_register    = 3'h3,
        quotient_op            = 3'h4
    } op_t;

    // Multiplier pass sequencer, one-hot.
    typedef enum logic [2:0] {
        MUL_IDLE   = 3'h1,
        MUL_FIRST  = 3'h2,
        MUL_SECOND = 3'h4
    } mul_state_t;

    // Divider iteration sequencer, one-hot.
    typedef enum logic [1:0] {
        DIV_IDLE = 2'h1,
        DIV_RUN  = 2'h2
    } div_state_t;

endpackage

// *** pq_unit_chk.sv ***
// Concurrent checks on the product and quotient unit, seen at its ports.
// Assumes one clock domain with an active-low asynchronous reset.
module pq_unit_chk
    import pq_types_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        clk_en,
    input wire logic        issue_valid,
    input wire op_t         issue_op,
    input wire logic        issue_signed,
    input wire logic [31:0] operand_a,
    input wire logic [31:0] operand_b,
    input wire logic        issue_stall,
    input wire logic [31:0] upper_result,
    input wire logic [31:0] bottom_result,
    input wire logic [31:0] gpr_result,
    input wire logic        gpr_valid,
    input wire logic        div_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic        take;        // An issue is taken at this edge.
    logic        mul;         // The offered operation is a multiply.
    logic        b16;         // The second operand fits one pass.
    logic        a8;          // The dividend fits eight bits.
    logic [63:0] sa, sb;      // Operands extended by their signedness.
    logic [63:0] prod;        // Exact product of the offered operands.
    logic [31:0] plo;         // Low word of that product.
    logic [5:0]  scnt;        // Stalled clocks in a row so far.
    assign take = clk_en && issue_valid && !issue_stall;
    assign mul = issue_op != quotient_op;
    assign b16 = issue_signed ? (&operand_b[31:15] || !(|operand_b[31:15]))
                              : !(|operand_b[31:16]);
    assign a8 = issue_signed ? (&operand_a[31:7] || !(|operand_a[31:7]))
                             : !(|operand_a[31:8]);
    assign sa = issue_signed ? {{32{operand_a[31]}}, operand_a}
                             : {32'h0, operand_a};
    assign sb = issue_signed ? {{32{operand_b[31]}}, operand_b}
                             : {32'h0, operand_b};
    assign prod = sa * sb;
    assign plo = prod[31:0];
    // Counts stall length, so a stuck interlock is caught with a bound.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            scnt <= 6'h00;
        end else if (clk_en) begin
            scnt <= issue_stall ? scnt + 6'h01 : 6'h00;
        end
    end
    property p_pass1; take && mul && b16 |=> !issue_stall; endproperty
    property p_pass2; take && mul && !b16 |=> issue_stall; endproperty
    property p_acc1;
        take && issue_op == product_to_accumulator && b16
        |-> ##2 {upper_result, bottom_result} == $past(prod, 2);
    endproperty
    property p_acc2;
        take && issue_op == product_to_accumulator && !b16
        |-> ##3 {upper_result, bottom_result} == $past(prod, 3);
    endproperty
    property p_gpr1;
        take && issue_op == product_to_register && b16
        |-> ##3 gpr_valid && gpr_result == $past(plo, 3);
    endproperty
    property p_gpr2;
        take && issue_op == product_to_register && !b16
        |-> ##4 gpr_valid && gpr_result == $past(plo, 4);
    endproperty
    property p_div8;
        take && issue_op == quotient_op && a8 |-> ##1 issue_stall [*8]
        ##1 issue_stall ##1 issue_stall ##1 !issue_stall;
    endproperty
    property p_stall_max; issue_stall |-> scnt < 6'h1F; endproperty
    a_pass1: assert property (p_pass1)
        else $error("stall after a one-pass multiply");
    a_pass2: assert property (p_pass2)
        else $error("no stall after a two-pass multiply");
    a_acc1: assert property (p_acc1)
        else $error("one-pass product wrong or late");
    a_acc2: assert property (p_acc2)
        else $error("two-pass product wrong or late");
    a_gpr1: assert property (p_gpr1)
        else $error("one-pass register product wrong or late");
    a_gpr2: assert property (p_gpr2)
        else $error("two-pass register product wrong or late");
    a_div8: assert property (p_div8)
        else $error("short divide stall window wrong");
    a_stall_max: assert property (p_stall_max)
        else $error("stall lasted too long");
    c_div8: cover property (take && issue_op == quotient_op && a8);
    c_pass2: cover property (take && mul && !b16);
    c_gpr: cover property (gpr_valid);
endmodule // pq_unit_chk

bind product_quotient_unit pq_unit_chk u_chk (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .issue_valid(issue_valid), .issue_op(issue_op),
    .issue_signed(issue_signed), .operand_a(operand_a),
    .operand_b(operand_b), .issue_stall(issue_stall),
    .upper_result(upper_result), .bottom_result(bottom_result),
    .gpr_result(gpr_result), .gpr_valid(gpr_valid), .div_busy(div_busy)
);

// *** pq_unit_consts.svh ***
// Timing and sizing constants for the product and quotient unit.
// Assumes it is included by bare name from every file that needs them.
`ifndef PQ_UNIT_CONSTS_SVH
`define PQ_UNIT_CONSTS_SVH

// Width of each operand and of each result register half.
`define OPND_W 32
// Width of the second-operand slice taken by one multiplier pass.
`define SLICE_W 16

// Iterations skipped by the early-in check, by dividend width class.
`define DIV8_SKIP 5'h17
`define DIV16_SKIP 5'h0F
`define DIV24_SKIP 5'h07
`define DIV32_SKIP 5'h00

// Divide latency in clocks, by dividend width class.
`define DIV8_LAT 6'h0C
`define DIV16_LAT 6'h13
`define DIV24_LAT 6'h1A
`define DIV32_LAT 6'h21

// Full iteration count of the one-bit-per-clock divider.
`define DIV_FULL_ITER 6'h20

// Remaining clocks before a divide writes back at which issue reopens.
`define DIV_ISSUE_WINDOW 6'h02

`endif

// *** product_quotient_unit.sv ***
// Multiply and divide unit that sits beside the integer pipe.
// Assumes the integer pipe holds an issue while issue_stall is high.
`include "pq_unit_consts.svh"

module product_quotient_unit
    import pq_types_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        issue_valid,
    input  wire op_t         issue_op,
    input  wire logic        issue_signed,
    input  wire logic [31:0] operand_a,
    input  wire logic [31:0] operand_b,
    output logic             issue_stall,
    output logic      [31:0] upper_result,
    output logic      [31:0] bottom_result,
    output logic      [31:0] gpr_result,
    output logic             gpr_valid,
    output logic             div_busy
);

    // Issue handshake.
    logic        accept;           // An operation is taken this clock.
    logic        is_mul;           // The issued operation is a multiply.
    logic        b_fits16;         // Second operand fits one pass.

    // Multiplier pipeline state.
    mul_state_t  mul_state;        // Which pass is pending.
    op_t         m_op;             // Operation in the multiplier.
    logic        m_signed;         // Signed operands.
    logic [31:0] m_a;              // First operand.
    logic [31:0] m_b;              // Second operand.
    logic        m_two;            // Needs two passes.
    logic [49:0] m_part;           // Low-slice product of pass one.
    logic [32:0] mcand;            // Booth multiplicand.
    logic [16:0] mplier;           // Booth multiplier slice.
    logic [49:0] booth_prod;       // Product of the current pass.
    logic        mul_final;        // The current pass is the last one.
    logic [63:0] full_product;     // Complete 64-bit product.
    logic [63:0] acc_src;          // Accumulator value to build on.
    logic [63:0] next_acc;         // New upper and bottom value.

    // Register-product stage.
    logic        gpr_stage_valid;  // Product waits one clock here.
    logic [31:0] gpr_stage;        // Low word of that product.

    // Divider state.
    div_state_t  div_state;        // Iterating or idle.
    logic [31:0] div_rem;          // Partial remainder.
    logic [31:0] div_q;            // Dividend shifting out, quotient in.
    logic [31:0] div_den;          // Divisor magnitude.
    logic        neg_q;            // Quotient must be negated.
    logic        neg_r;            // Remainder must be negated.
    logic [5:0]  iter_cnt;         // Iterations left.
    logic [5:0]  wb_cnt;           // Clocks left until write-back.
    logic        wb_fire;          // Write-back happens at this edge.
    logic [31:0] hold_q;           // Finished quotient awaiting write.
    logic [31:0] hold_r;           // Finished remainder awaiting write.

    // Divider load and step values.
    logic [31:0] a_abs;            // Dividend magnitude.
    logic [31:0] b_abs;            // Divisor magnitude.
    logic [4:0]  div_skip;         // Iterations skipped by early-in.
    logic [5:0]  div_lat;          // Latency of this divide.
    logic [32:0] trial;            // Shifted remainder minus divisor.
    logic [32:0] rem_shift;        // Remainder with next dividend bit.
    logic [31:0] step_rem;         // Remainder after one iteration.
    logic [31:0] step_q;           // Quotient after one iteration.

    // Multiply when the operation is anything but a divide.
    assign is_mul = (issue_op != quotient_op);

    // Only the second operand decides the pass count.
    always_comb begin
        if (issue_signed) begin
            b_fits16 = (&operand_b[31:15]) | ~(|operand_b[31:15]);
        end else begin
            b_fits16 = ~(|operand_b[31:16]);
        end
    end

    // Issue closes while a second pass is due or a divide is far from done.
    always_comb begin
        issue_stall = 1'b0;
        if (mul_state == MUL_FIRST && m_two) begin
            issue_stall = 1'b1;
        end
        if (wb_cnt > `DIV_ISSUE_WINDOW) begin
            issue_stall = 1'b1;
        end
    end

    // A frozen clock enable takes nothing.
    assign accept = clk_en & issue_valid & ~issue_stall;

    // Divider activity seen from outside.
    assign div_busy = (div_state == DIV_RUN) | (wb_cnt != 6'h00) | wb_fire;

    // Booth operands: signed operands carry their sign in the top bit.
    always_comb begin
        mcand = {m_signed & m_a[31], m_a};
        if (mul_state == MUL_SECOND) begin
            mplier = {m_signed & m_b[31], m_b[31:16]};
        end else if (m_two) begin
            mplier = {1'b0, m_b[15:0]};
        end else begin
            mplier = {m_signed & m_b[15], m_b[15:0]};
        end
    end

    // One pass through the 32x16 array per clock.
    booth_mult_33x17 u_booth (
        .multiplicand (mcand),
        .multiplier   (mplier),
        .product      (booth_prod)
    );

    // The last pass is the only pass of a short operand, else the second.
    assign mul_final = (mul_state == MUL_FIRST && !m_two)
                     | (mul_state == MUL_SECOND);

    // The second pass weighs the upper slice by 16 bits over the first.
    always_comb begin
        if (mul_state == MUL_SECOND) begin
            full_product = {booth_prod[47:0], 16'h0000}
                         + {{14{m_part[49]}}, m_part};
        end else begin
            full_product = {{14{booth_prod[49]}}, booth_prod};
        end
    end

    // A divide that lands this edge is forwarded into an accumulation.
    assign acc_src = wb_fire ? {hold_r, hold_q}
                             : {upper_result, bottom_result};

    // Accumulator update by operation.
    always_comb begin
        unique case (m_op)
            product_accumulate_add: next_acc = acc_src + full_product;
            product_accumulate_sub: next_acc = acc_src - full_product;
            default:                next_acc = full_product;
        endcase
    end

    // Pass sequencer; it advances regardless of integer pipe stalls.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mul_state <= MUL_IDLE;
        end else if (clk_en) begin
            if (accept && is_mul) begin
                mul_state <= MUL_FIRST;
            end else if (mul_state == MUL_FIRST && m_two) begin
                mul_state <= MUL_SECOND;
            end else begin
                mul_state <= MUL_IDLE;
            end
        end
    end

    // Operand capture at issue and the pass-one partial product.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            m_op     <= product_to_accumulator;
            m_signed <= 1'b0;
            m_a      <= '0;
            m_b      <= '0;
            m_two    <= 1'b0;
            m_part   <= '0;
        end else if (clk_en) begin
            if (accept && is_mul) begin
                m_op     <= issue_op;
                m_signed <= issue_signed;
                m_a      <= operand_a;
                m_b      <= operand_b;
                m_two    <= ~b_fits16;
            end
            if (mul_state == MUL_FIRST && m_two) begin
                m_part <= booth_prod;
            end
        end
    end

    // Upper and bottom results; a multiply landing with a divide wins.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            upper_result  <= '0;
            bottom_result <= '0;
        end else if (clk_en) begin
            if (mul_final && m_op != product_to_register) begin
                upper_result  <= next_acc[63:32];
                bottom_result <= next_acc[31:0];
            end else if (wb_fire) begin
                upper_result  <= hold_r;
                bottom_result <= hold_q;
            end
        end
    end

    // Register products take one more clock than accumulator products.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gpr_stage_valid <= 1'b0;
            gpr_stage       <= '0;
            gpr_valid       <= 1'b0;
            gpr_result      <= '0;
        end else if (clk_en) begin
            gpr_stage_valid <= mul_final && m_op == product_to_register;
            if (mul_final && m_op == product_to_register) begin
                gpr_stage <= full_product[31:0];
            end
            gpr_valid <= gpr_stage_valid;
            if (gpr_stage_valid) begin
                gpr_result <= gpr_stage;
            end
        end
    end

    // Divide operand magnitudes and signs.
    always_comb begin
        a_abs = (issue_signed && operand_a[31]) ? -operand_a : operand_a;
        b_abs = (issue_signed && operand_b[31]) ? -operand_b : operand_b;
    end

    // Early-in check on the sign extension of the dividend.
    always_comb begin
        div_skip = `DIV32_SKIP;
        div_lat  = `DIV32_LAT;
        if (issue_signed ? (&operand_a[31:7]) | ~(|operand_a[31:7])
                         : ~(|operand_a[31:8])) begin
            div_skip = `DIV8_SKIP;
            div_lat  = `DIV8_LAT;
        end else if (issue_signed ? (&operand_a[31:15]) | ~(|operand_a[31:15])
                                  : ~(|operand_a[31:16])) begin
            div_skip = `DIV16_SKIP;
            div_lat  = `DIV16_LAT;
        end else if (issue_signed ? (&operand_a[31:23]) | ~(|operand_a[31:23])
                                  : ~(|operand_a[31:24])) begin
            div_skip = `DIV24_SKIP;
            div_lat  = `DIV24_LAT;
        end
    end

    // Restoring step: shift in one dividend bit, subtract if it fits.
    always_comb begin
        rem_shift = {div_rem, div_q[31]};
        trial     = rem_shift - {1'b0, div_den};
        if (!trial[32]) begin
            step_rem = trial[31:0];
            step_q   = {div_q[30:0], 1'b1};
        end else begin
            step_rem = rem_shift[31:0];
            step_q   = {div_q[30:0], 1'b0};
        end
    end

    // Divider iterations; a new divide may load on the last iteration.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            div_state <= DIV_IDLE;
            div_rem   <= '0;
            div_q     <= '0;
            div_den   <= '0;
            neg_q     <= 1'b0;
            neg_r     <= 1'b0;
            iter_cnt  <= '0;
        end else if (clk_en) begin
            if (accept && !is_mul) begin
                div_state <= DIV_RUN;
                div_rem   <= '0;
                div_q     <= a_abs << div_skip;
                div_den   <= b_abs;
                neg_q     <= issue_signed & (operand_a[31] ^ operand_b[31]);
                neg_r     <= issue_signed & operand_a[31];
                iter_cnt  <= `DIV_FULL_ITER - {1'b0, div_skip};
            end else if (div_state == DIV_RUN) begin
                div_rem  <= step_rem;
                div_q    <= step_q;
                iter_cnt <= iter_cnt - 6'h01;
                if (iter_cnt == 6'h01) begin
                    div_state <= DIV_IDLE;
                end
            end
        end
    end

    // Finished results are held, sign-corrected, until write-back.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hold_q <= '0;
            hold_r <= '0;
        end else if (clk_en) begin
            if (div_state == DIV_RUN && iter_cnt == 6'h01) begin
                hold_q <= neg_q ? -step_q : step_q;
                hold_r <= neg_r ? -step_rem : step_rem;
            end
        end
    end

    // Write-back countdown sets the divide latency; issue reopens one early.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wb_cnt  <= '0;
            wb_fire <= 1'b0;
        end else if (clk_en) begin
            wb_fire <= (wb_cnt == `DIV_ISSUE_WINDOW);
            if (accept && !is_mul) begin
                wb_cnt <= div_lat;
            end else if (wb_cnt != 6'h00) begin
                wb_cnt <= wb_cnt - 6'h01;
            end
        end
    end

endmodule // product_quotient_unit

// *** testbench.sv ***
// Self-checking bench for the product and quotient unit.
// Assumes the issue_pipe model and the bound checker are compiled first.
module testbench
    import pq_types_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Starts low by declaration, so time zero shows no false falling edge.
    logic        core_clk = 1'b0;
    logic        resetn, clk_en, issue_valid, issue_signed;
    logic        issue_stall, gpr_valid, div_busy, timed_out;
    op_t         issue_op;
    logic [31:0] operand_a, operand_b, upper_result, bottom_result;
    logic [31:0] gpr_result;
    logic [31:0] hu [0:4095], hb [0:4095], hg [0:4095]; // Output log.
    logic        hv [0:4095];                           // Pulse log.
    logic        hd [0:4095];                           // Busy log.
    int          ncyc, n_errors, checks;
    product_quotient_unit uut (
        .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
        .issue_valid(issue_valid), .issue_op(issue_op),
        .issue_signed(issue_signed), .operand_a(operand_a),
        .operand_b(operand_b), .issue_stall(issue_stall),
        .upper_result(upper_result), .bottom_result(bottom_result),
        .gpr_result(gpr_result), .gpr_valid(gpr_valid), .div_busy(div_busy)
    );
    issue_pipe u_pipe (
        .core_clk(core_clk), .issue_stall(issue_stall),
        .issue_valid(issue_valid), .issue_op(issue_op),
        .issue_signed(issue_signed), .operand_a(operand_a),
        .operand_b(operand_b), .timed_out(timed_out)
    );
    // Free-running clock with an 8 ns period.
    always #4 core_clk = ~core_clk;
    // Logs settled outputs after each rising edge, by edge number.
    always @(negedge core_clk) begin
        ncyc++;
        hu[ncyc] = upper_result;
        hb[ncyc] = bottom_result;
        hg[ncyc] = gpr_result;
        hv[ncyc] = gpr_valid;
        hd[ncyc] = div_busy;
    end
    // Compares a result value and counts the outcome.
    task automatic cmp(input string what, input logic [63:0] got,
                       input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Compares an issue spacing in clocks.
    task automatic cmp_cyc(input int exp, input int got);
        checks++;
        if (got != exp) begin
            n_errors++;
            $display("unexpected spacing: expected %0d, seen %0d", exp, got);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d, errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Offers through the pipe model; a hung stall ends the run.
    task automatic put(input op_t op, input logic sg,
                       input logic [31:0] a, input logic [31:0] b);
        u_pipe.offer(op, sg, a, b);
        if (timed_out === 1'b1) begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    // Main sequence: every operation, every width class, back to back.
    initial begin
        logic [63:0] acc, pr, nxt, sa, sb;
        logic [31:0] a, b, r;
        logic        sg, wide;
        int          e1, e2, lat, rate, k, s;
        op_t         op;
        resetn = 1'b0;
        clk_en = 1'b1;
        ncyc = 0;
        n_errors = 0;
        checks = 0;
        acc = 64'h0;
        void'($urandom(32'hCFEE));
        repeat (4) @(negedge core_clk);
        resetn = 1'b1;
        cmp("reset", {upper_result, bottom_result}, 64'h0);
        cmp("reset flags", {issue_stall, div_busy, gpr_valid, gpr_result},
            64'h0);
        for (int i = 0; i < 40; i++) begin
            op = op_t'(i % 5);
            r = $urandom;
            sg = r[0];
            wide = r[3];
            k = (i / 5) % 4;
            s = 24 - 8 * k;
            a = $urandom;
            if (op == quotient_op) begin
                // Dividend sized to fit 8*(k+1) bits but not fewer.
                if (sg) begin
                    a = $signed(a << s) >>> s;
                end else begin
                    a = a >> s;
                end
                // The top bit of the class, or the bit below it if signed, breaks the narrower fit.
                if (k > 0) begin
                    if (sg) begin
                        a[30 - s] = ~a[31 - s];
                    end else begin
                        a[31 - s] = 1'b1;
                    end
                end
                b = ($urandom % 200) + 1;
                b = (sg && r[1]) ? -b : b;
                nxt = sg ? {32'($signed(a) % $signed(b)),
                            32'($signed(a) / $signed(b))}
                         : {a % b, a / b};
                lat = 12 + 7 * k;
                rate = lat - 1;
            end else begin
                // Second operand either one slice wide or a full word.
                b = wide ? {r[31], ~r[31], r[29:0]}
                         : (sg ? {{16{r[15]}}, r[15:0]} : {16'h0, r[15:0]});
                sa = sg ? {{32{a[31]}}, a} : {32'h0, a};
                sb = sg ? {{32{b[31]}}, b} : {32'h0, b};
                pr = sa * sb;
                case (op)
                    product_to_accumulator: nxt = pr;
                    product_accumulate_add: nxt = acc + pr;
                    product_accumulate_sub: nxt = acc - pr;
                    default: nxt = acc;
                endcase
                lat = (op == product_to_register ? 2 : 1) + int'(wide);
                rate = 1 + int'(wide);
            end
            put(op, sg, a, b);
            e1 = ncyc + 1;
            put(product_to_register, 1'b0, i, 32'h3);
            e2 = ncyc + 1;
            u_pipe.rest();
            repeat (lat + 4) @(negedge core_clk);
            cmp_cyc(rate, e2 - e1);
            cmp("before", {hu[e1+lat-1], hb[e1+lat-1]}, acc);
            cmp("after", {hu[e1+lat], hb[e1+lat]}, nxt);
            if (op == product_to_register) begin
                cmp("gpr", {hv[e1+lat-1], hv[e1+lat], hg[e1+lat]},
                    {2'b01, pr[31:0]});
            end
            cmp("follow", {hv[e2+2], hg[e2+2]}, {1'b1, 32'(i * 3)});
            cmp("busy", {hd[e1], hd[e1+lat-1], hd[e1+lat]},
                (op == quotient_op) ? 64'h6 : 64'h0);
            acc = nxt;
        end
        tally_and_finish();
    end
endmodule // testbench
